// ---- aea_regs.svh ----
`ifndef AEA_REGS_SVH
`define AEA_REGS_SVH
// Behaviour
// - flag each phase whose power goes negative
// - sign bits 12-14 of frequency numerator
// - disabled phase forces its sign bit low
// - mode bit 5 enables phase A, bit 12
// - power sum mode from mode bits 7:6
// - each term gated by its select bit
// - mode picks the per-phase product combination
// - products use gain-corrected current samples
// - add offset, scale by one plus gain/4096
// - accumulate total power into 54-bit register
// - one sample added every 0.4 microseconds
// - signed addition, negative power subtracts
// - divide by divider, zero acts as one
// - readout is upper 24 bits of quotient
// - clearing read zeroes accumulator, plain does not
// - positive overflow wraps to most negative
// - negative underflow wraps to most positive
// - half-full energy raises enabled active-low interrupt
// - sub-threshold phase power ignored unless disabled
// - gain bit 2 selects absolute-value summation

`define AEA_ADDR_RO      7'h01
`define AEA_ADDR_RC      7'h02
`define AEA_ADDR_DIV     7'h03
`define AEA_ADDR_MODE    7'h04
`define AEA_ADDR_FNUM    7'h05
`define AEA_ADDR_IRQEN   7'h06
`define AEA_ADDR_STAT    7'h07
`define AEA_ADDR_PGAIN   7'h08
`define AEA_ADDR_POFFS   7'h0B
`define AEA_ADDR_PHASE_WATT_GAIN   7'h0E
`define AEA_ADDR_GAIN    7'h18

`define AEA_RST_DIV      8'h00
`define AEA_RST_MODE     8'h3F
`define AEA_RST_GAIN     8'h00
`define AEA_RST_FNUM     12'h000
`define AEA_RST_IRQEN    1'h0
`define AEA_PIN_IDLE     3'h2

`define AEA_MODE_MSB     7
`define AEA_MODE_LSB     6
`define AEA_SEL_A        5
`define AEA_SEL_B        4
`define AEA_SEL_C        3
`define AEA_GAIN_ABS     2
`define AEA_GAIN_NLT_OFF 3
`define AEA_FNUM_SIGN    12

`define AEA_NO_LOAD      36'h2AF
`define AEA_PHASE_WATT_GAIN_SHIFT  12
`define AEA_ACC_W        54
`define AEA_CMD_LAST     5'h07
`define AEA_FRAME_LAST   5'h1F
`define AEA_CLK_MHZ      40
`define AEA_SAMPLE_NS    400
`define AEA_SAMPLE_CYC   ((`AEA_SAMPLE_NS * `AEA_CLK_MHZ) / 1000)
`endif

// ---- aea_pkg.sv ----
`default_nettype none
package aea_pkg;
  typedef struct packed {
    logic signed [15:0] volt;
    logic signed [15:0] cur;
  } aea_sample_t;

  typedef struct packed {
    logic signed [11:0] pgain;
    logic signed [11:0] poffs;
    logic signed [11:0] phase_watt_gain;
  } aea_cal_t;

  typedef enum logic [1:0] {SPI_IDLE, SPI_CMD, SPI_DATA, SPI_DONE} aea_spi_t;
endpackage : aea_pkg
`default_nettype wire

// ---- aea_phase_term.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "aea_regs.svh"
module aea_phase_term (
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  ce_in,
  input  wire logic signed [15:0]    volt_in,
  input  wire logic signed [17:0]    cur_in,
  input  wire aea_pkg::aea_cal_t     cal_in,
  input  wire logic                  enable_in,
  input  wire logic                  nlt_off_in,
  input  wire logic                  abs_mode_in,
  output var  logic signed [35:0]    term_out,
  output var  logic                  neg_out
);
  wire signed [33:0] prod_w   = volt_in * cur_in;
  wire signed [34:0] offs_w   = 35'(prod_w) + 35'(cal_in.poffs);
  wire signed [46:0] wprod_w  = offs_w * cal_in.phase_watt_gain;
  wire signed [35:0] scaled_w = 36'(offs_w) + 36'(wprod_w >>> `AEA_PHASE_WATT_GAIN_SHIFT);
  wire               neg_w    = scaled_w[35];
  wire signed [35:0] mag_w    = neg_w ? -scaled_w : scaled_w;
  // creep suppression looks at magnitude so both directions are treated alike
  wire               small_w  = !nlt_off_in && (mag_w < `AEA_NO_LOAD);
  wire signed [35:0] pick_w   = abs_mode_in ? mag_w : scaled_w;
  wire signed [35:0] term_w   = (!enable_in || small_w) ? '0 : pick_w;

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      term_out <= '0;
      neg_out  <= 1'b0;
    end
    else if (ce_in)
    begin
      term_out <= term_w;
      neg_out  <= enable_in && neg_w;
    end
  end

  a_off_term_zero : assert property (
    @(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    !enable_in |=> (term_out == '0) && !neg_out)
    else $error("disabled phase still contributes");
  a_sign_follow : assert property (
    @(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    enable_in |=> neg_out == $past(scaled_w[35]))
    else $error("phase sign flag wrong");
  a_no_load_gate : assert property (
    @(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    (!nlt_off_in && (mag_w < `AEA_NO_LOAD)) |=> term_out == '0)
    else $error("power below threshold was passed");
  a_abs_positive : assert property (
    @(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    (abs_mode_in && (scaled_w != {1'b1, 35'h0})) |=> !term_out[35])
    else $error("absolute mode produced negative term");
  a_unity_gain : assert property (
    @(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    (enable_in && nlt_off_in && !abs_mode_in && cal_in.phase_watt_gain == 12'h000)
    |=> term_out == $past(36'(offs_w)))
    else $error("offset path wrong at unity gain");
endmodule : aea_phase_term
`default_nettype wire

// ---- aea_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "aea_regs.svh"
module aea_top (
  input  wire logic                        clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic                        ce_in,
  input  wire aea_pkg::aea_sample_t [2:0]  samples_in,
  input  wire logic                        sclk_in,
  input  wire logic                        cs_n_in,
  input  wire logic                        din_in,
  output var  logic                        dout_out,
  output var  logic                        irq_n_out
);
  // current after per-phase gain correction, one extra bit of headroom
  function automatic logic signed [16:0] gain_cur(input logic signed [15:0] i,
                                                   input logic signed [11:0] g);
    logic signed [27:0] p;
    p = i * g;
    gain_cur = 17'(i) + 17'(p >>> `AEA_PHASE_WATT_GAIN_SHIFT);
  endfunction : gain_cur

  // pin synchronisers: sclk, cs_n, din
  logic [2:0]                s1_reg;
  logic [2:0]                s2_reg;
  logic                      sclk_d_reg;
  aea_pkg::aea_spi_t         st_reg;
  aea_pkg::aea_spi_t         st_next;
  logic [4:0]                bit_reg;
  logic [23:0]               sh_reg;
  logic [7:0]                cmd_reg;
  logic [23:0]               tx_reg;
  logic [23:0]               rd_w;
  logic [7:0]                div_reg;
  logic [7:0]                mode_reg;
  logic [7:0]                gain_reg;
  logic [11:0]               fnum_reg;
  logic                      irqen_reg;
  logic                      stat_reg;
  logic                      half_d_reg;
  logic [2:0]                rev_reg;
  logic [3:0]                cnt_reg;
  logic signed [53:0]        acc_reg;
  logic signed [53:0]        acc_next;
  logic [23:0]               energy_reg;
  aea_pkg::aea_cal_t         cal_reg [3];
  logic signed [35:0]        term_w [3];
  logic [2:0]                neg_w;

  wire        rise_w    = s2_reg[2] && !sclk_d_reg;
  wire        cs_act_w  = !s2_reg[1];
  wire        din_s_w   = s2_reg[0];
  wire        cmd_done  = rise_w && (st_reg == aea_pkg::SPI_CMD) && (bit_reg == `AEA_CMD_LAST);
  wire [7:0]  cmd_w     = {sh_reg[6:0], din_s_w};
  wire        rd_start  = cmd_done && !cmd_w[7];
  wire [23:0] wr_data   = {sh_reg[22:0], din_s_w};
  wire [6:0]  wr_addr   = cmd_reg[6:0];
  wire        data_rise = rise_w && (st_reg == aea_pkg::SPI_DATA);
  wire        wr_fire   = data_rise && (bit_reg == `AEA_FRAME_LAST) && cmd_reg[7];
  wire        rc_clear  = rd_start && (cmd_w[6:0] == `AEA_ADDR_RC);
  wire        st_clear  = rd_start && (cmd_w[6:0] == `AEA_ADDR_STAT);

  // summation mode and term selection
  wire [1:0]  sum_mode  = mode_reg[`AEA_MODE_MSB:`AEA_MODE_LSB];
  wire        diff_mode = (sum_mode == 2'h1) || (sum_mode == 2'h2);
  wire [2:0]  en_w      = {mode_reg[`AEA_SEL_C],
                           mode_reg[`AEA_SEL_B] && !diff_mode,
                           mode_reg[`AEA_SEL_A]};
  wire signed [16:0] ia_w = gain_cur(samples_in[0].cur, cal_reg[0].pgain);
  wire signed [16:0] ib_w = gain_cur(samples_in[1].cur, cal_reg[1].pgain);
  wire signed [16:0] ic_w = gain_cur(samples_in[2].cur, cal_reg[2].pgain);
  wire signed [17:0] cur_a = diff_mode ? 18'(ia_w) - 18'(ib_w) : 18'(ia_w);
  wire signed [17:0] cur_b = 18'(ib_w);
  wire signed [17:0] cur_c = (sum_mode == 2'h1) ? 18'(ic_w) - 18'(ib_w) : 18'(ic_w);
  wire signed [17:0] cur_w [3];
  assign cur_w[0] = cur_a;
  assign cur_w[1] = cur_b;
  assign cur_w[2] = cur_c;

  genvar gp;
  generate
    for (gp = 0; gp < 3; gp++)
    begin : g_phase
      aea_phase_term u_term (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .ce_in       (ce_in),
        .volt_in     (samples_in[gp].volt),
        .cur_in      (cur_w[gp]),
        .cal_in      (cal_reg[gp]),
        .enable_in   (en_w[gp]),
        .nlt_off_in  (gain_reg[`AEA_GAIN_NLT_OFF]),
        .abs_mode_in (gain_reg[`AEA_GAIN_ABS]),
        .term_out    (term_w[gp]),
        .neg_out     (neg_w[gp])
      );
    end
  endgenerate

  // accumulation: one sample per period, signed
  wire signed [53:0] sum_w = 54'(term_w[0]) + 54'(term_w[1]) + 54'(term_w[2]);
  wire               tick  = (cnt_reg == 4'(`AEA_SAMPLE_CYC - 1));

  always_comb
  begin
    acc_next = acc_reg;
    if (rc_clear)
      acc_next = tick ? sum_w : '0;
    else if (tick)
      acc_next = acc_reg + sum_w;
  end

  // divider of zero means one; a full divide keeps the quotient exact
  wire [7:0]         div_eff = (div_reg == 8'h00) ? 8'h01 : div_reg;
  wire signed [53:0] quot_w  = acc_reg / $signed({1'b0, div_eff});
  // plain twos complement truncation gives the documented wrap both ways
  wire [23:0]        energy_w = quot_w[53:30];
  wire               half_w   = energy_reg[23] ^ energy_reg[22];
  wire               half_evt = half_w && !half_d_reg;

  always_comb
  begin
    rd_w = '0;
    case (cmd_w[6:0])
      `AEA_ADDR_RO:    rd_w = energy_reg;
      `AEA_ADDR_RC:    rd_w = energy_reg;
      `AEA_ADDR_DIV:   rd_w = {16'h0000, div_reg};
      `AEA_ADDR_MODE:  rd_w = {16'h0000, mode_reg};
      `AEA_ADDR_FNUM:  rd_w = {9'h000, rev_reg & en_w, fnum_reg};
      `AEA_ADDR_IRQEN: rd_w = {23'h00_0000, irqen_reg};
      `AEA_ADDR_STAT:  rd_w = {23'h00_0000, stat_reg};
      `AEA_ADDR_GAIN:  rd_w = {16'h0000, gain_reg};
      default:         rd_w = '0;
    endcase
    for (int p = 0; p < 3; p++)
    begin
      if (cmd_w[6:0] == `AEA_ADDR_PGAIN + 7'(p))
        rd_w = {12'h000, cal_reg[p].pgain};
      if (cmd_w[6:0] == `AEA_ADDR_POFFS + 7'(p))
        rd_w = {12'h000, cal_reg[p].poffs};
      if (cmd_w[6:0] == `AEA_ADDR_PHASE_WATT_GAIN + 7'(p))
        rd_w = {12'h000, cal_reg[p].phase_watt_gain};
    end
  end

  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      aea_pkg::SPI_IDLE: st_next = aea_pkg::SPI_CMD;
      aea_pkg::SPI_CMD:  if (cmd_done) st_next = aea_pkg::SPI_DATA;
      aea_pkg::SPI_DATA: if (data_rise && bit_reg == `AEA_FRAME_LAST) st_next = aea_pkg::SPI_DONE;
      aea_pkg::SPI_DONE: st_next = aea_pkg::SPI_DONE;
      default:           st_next = aea_pkg::SPI_IDLE;
    endcase
    if (!cs_act_w)
      st_next = aea_pkg::SPI_IDLE;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      s1_reg     <= `AEA_PIN_IDLE;
      s2_reg     <= `AEA_PIN_IDLE;
      sclk_d_reg <= 1'b0;
    end
    else if (ce_in)
    begin
      s1_reg     <= {sclk_in, cs_n_in, din_in};
      s2_reg     <= s1_reg;
      sclk_d_reg <= s2_reg[2];
    end
  end

  // serial shifter: device drives dout after sclk rise, host samples on fall
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      st_reg   <= aea_pkg::SPI_IDLE;
      bit_reg  <= '0;
      sh_reg   <= '0;
      cmd_reg  <= '0;
      tx_reg   <= '0;
      dout_out <= 1'b0;
    end
    else if (ce_in)
    begin
      st_reg  <= st_next;
      bit_reg <= !cs_act_w ? 5'h00 : (rise_w ? bit_reg + 5'h01 : bit_reg);
      if (rise_w)
        sh_reg <= wr_data;
      if (cmd_done)
        cmd_reg <= cmd_w;
      if (rd_start)
        tx_reg <= {rd_w[22:0], 1'b0};
      else if (data_rise)
        tx_reg <= {tx_reg[22:0], 1'b0};
      if (!cs_act_w)
        dout_out <= 1'b0;
      else if (rd_start)
        dout_out <= rd_w[23];
      else if (data_rise && !cmd_reg[7])
        dout_out <= tx_reg[23];
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      div_reg   <= `AEA_RST_DIV;
      mode_reg  <= `AEA_RST_MODE;
      gain_reg  <= `AEA_RST_GAIN;
      fnum_reg  <= `AEA_RST_FNUM;
      irqen_reg <= `AEA_RST_IRQEN;
      for (int p = 0; p < 3; p++)
        cal_reg[p] <= '0;
    end
    else if (ce_in && wr_fire)
    begin
      if (wr_addr == `AEA_ADDR_DIV)
        div_reg <= wr_data[7:0];
      if (wr_addr == `AEA_ADDR_MODE)
        mode_reg <= wr_data[7:0];
      if (wr_addr == `AEA_ADDR_GAIN)
        gain_reg <= wr_data[7:0];
      if (wr_addr == `AEA_ADDR_FNUM)
        fnum_reg <= wr_data[11:0];
      if (wr_addr == `AEA_ADDR_IRQEN)
        irqen_reg <= wr_data[0];
      for (int p = 0; p < 3; p++)
      begin
        if (wr_addr == `AEA_ADDR_PGAIN + 7'(p))
          cal_reg[p].pgain <= wr_data[11:0];
        if (wr_addr == `AEA_ADDR_POFFS + 7'(p))
          cal_reg[p].poffs <= wr_data[11:0];
        if (wr_addr == `AEA_ADDR_PHASE_WATT_GAIN + 7'(p))
          cal_reg[p].phase_watt_gain <= wr_data[11:0];
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_reg    <= '0;
      acc_reg    <= '0;
      energy_reg <= '0;
      rev_reg    <= '0;
      half_d_reg <= 1'b0;
      stat_reg   <= 1'b0;
      irq_n_out  <= 1'b1;
    end
    else if (ce_in)
    begin
      cnt_reg    <= tick ? 4'h0 : cnt_reg + 4'h1;
      acc_reg    <= acc_next;
      energy_reg <= energy_w;
      if (tick)
        rev_reg <= neg_w;
      half_d_reg <= half_w;
      // a crossing in the clearing cycle is kept
      stat_reg   <= half_evt || (stat_reg && !st_clear);
      irq_n_out  <= !(stat_reg && irqen_reg);
    end
  end

  sequence s_half_evt;
    half_evt && irqen_reg && !wr_fire;
  endsequence
  sequence s_ro_read;
    rd_start && (cmd_w[6:0] == `AEA_ADDR_RO);
  endsequence

  a_acc_add : assert property (
    @(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    (tick && !rc_clear) |=> acc_reg == $past(acc_reg) + $past(sum_w))
    else $error("accumulator did not add sample");
  a_acc_hold : assert property (
    @(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    (!tick && !rc_clear) |=> $stable(acc_reg))
    else $error("accumulator changed between samples");
  a_tick_period : assert property (
    @(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    tick |-> ##16 tick)
    else $error("sample period wrong");
  a_rc_clears : assert property (
    @(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    (rc_clear && !tick) |=> acc_reg == '0)
    else $error("clearing read left accumulator");
  a_div_zero : assert property (
    @(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    (div_reg == 8'h00) |-> energy_w == acc_reg[53:30])
    else $error("zero divider not unity");
  a_b_excluded : assert property (
    @(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    diff_mode |=> term_w[1] == '0)
    else $error("phase b term used in difference mode");
  a_ro_capture : assert property (
    @(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    s_ro_read |=> dout_out == $past(energy_reg[23]))
    else $error("readout not captured at read start");
  a_irq_half : assert property (
    @(posedge clk_in) disable iff (!rst_n_in || !ce_in)
    s_half_evt |-> ##2 !irq_n_out)
    else $error("half full interrupt missing");
endmodule : aea_top
`default_nettype wire

// ---- aea_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module aea_host (
  input  wire logic clk_in,
  input  wire logic dout_in,
  output var  logic sclk_out,
  output var  logic cs_n_out,
  output var  logic din_out
);
  // six clocks per phase keeps the pins well above the two-flop sampling window
  localparam int HALF_CYC = 6;

  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out  = 1'b0;
  end

  // one frame: 8 command bits then 24 data bits, msb first, read data taken on sclk fall
  task automatic xfer(input logic [7:0] cmd, input logic [23:0] wdata, output logic [23:0] rdata);
    logic [31:0] word;
    word = {cmd, wdata};
    rdata = 24'h00_0000;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      din_out <= word[i];
      repeat (HALF_CYC) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (HALF_CYC) @(posedge clk_in);
      sclk_out <= 1'b0;
      if (i >= 1 && i <= 24)
        rdata = {rdata[22:0], dout_in};
    end
    repeat (HALF_CYC) @(posedge clk_in);
    cs_n_out <= 1'b1;
    // released data line is not held at its last level
    din_out <= ~word[0];
    repeat (HALF_CYC) @(posedge clk_in);
  endtask : xfer
endmodule : aea_host
`default_nettype wire

// ---- test_active_energy_accumulator.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "aea_regs.svh"
module test_active_energy_accumulator;
  typedef aea_pkg::aea_sample_t [2:0] aea_trio_t;
  localparam logic signed [15:0] FNEG = 16'h8000;
  localparam logic signed [15:0] HNEG = 16'hC000;
  localparam logic signed [15:0] HPOS = 16'h4000;
  localparam logic signed [15:0] ZERO = 16'h0000;
  logic        clk_in;
  logic        rst_n_in;
  logic        ce_in;
  logic        sclk_in;
  logic        cs_n_in;
  logic        din_in;
  logic        dout_out;
  logic        irq_n_out;
  logic [23:0] got;
  aea_trio_t   samples_in;
  int          fail_count;
  int          cmp_count;

  aea_top aea_top_inst (
    .clk_in    (clk_in),
    .rst_n_in  (rst_n_in),
    .ce_in     (ce_in),
    .samples_in(samples_in),
    .sclk_in   (sclk_in),
    .cs_n_in   (cs_n_in),
    .din_in    (din_in),
    .dout_out  (dout_out),
    .irq_n_out (irq_n_out)
  );

  aea_host aea_host_inst (
    .clk_in  (clk_in),
    .dout_in (dout_out),
    .sclk_out(sclk_in),
    .cs_n_out(cs_n_in),
    .din_out (din_in)
  );

  initial
  begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  function automatic aea_trio_t trio(logic signed [15:0] va, ia, vb, ib, vc, ic);
    trio = '{'{vc, ic}, '{vb, ib}, '{va, ia}};
  endfunction : trio

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic rd(input logic [6:0] addr, output logic [23:0] data);
    aea_host_inst.xfer({1'b0, addr}, 24'h00_0000, data);
  endtask : rd

  task automatic wr(input logic [6:0] addr, input logic [23:0] data);
    logic [23:0] dummy;
    aea_host_inst.xfer({1'b1, addr}, data, dummy);
  endtask : wr

  task automatic set_mode(input logic [1:0] mode, input logic [2:0] sel);
    wr(`AEA_ADDR_MODE, {16'h0000, mode, sel, 3'b111});
  endtask : set_mode

  // clear with idle inputs, then exactly k sample periods of s, then read the plain register
  task automatic measure(input aea_trio_t s, input int k, output logic [23:0] e);
    rd(`AEA_ADDR_RC, e);
    @(posedge clk_in);
    samples_in <= s;
    repeat (`AEA_SAMPLE_CYC * k) @(posedge clk_in);
    samples_in <= '0;
    rd(`AEA_ADDR_RO, e);
  endtask : measure

  task automatic t_reset();
    logic [6:0] addr [5] = '{`AEA_ADDR_DIV, `AEA_ADDR_MODE, `AEA_ADDR_GAIN, `AEA_ADDR_FNUM,
                             `AEA_ADDR_RO};
    logic [23:0] want [5] = '{24'h00_0000, 24'h00_003F, 24'h00_0000, 24'h00_0000, 24'h00_0000};
    for (int i = 0; i < 5; i++)
    begin
      rd(addr[i], got);
      check("reset value", got, want[i]);
    end
    check("irq idle", {23'h00_0000, irq_n_out}, 24'h00_0001);
    $display("done reset values");
  endtask : t_reset

  task automatic t_access();
    wr(`AEA_ADDR_DIV, 24'h00_00A5);
    rd(`AEA_ADDR_DIV, got);
    check("divider readback", got, 24'h00_00A5);
    wr(`AEA_ADDR_RO, 24'h12_3456);
    rd(`AEA_ADDR_RO, got);
    check("read-only write", got, 24'h00_0000);
    rd(7'h7F, got);
    check("unmapped read", got, 24'h00_0000);
    wr(`AEA_ADDR_DIV, 24'h00_0000);
    wr(`AEA_ADDR_IRQEN, 24'h00_0001);
    rd(`AEA_ADDR_IRQEN, got);
    check("irq enable readback", got, 24'h00_0001);
    rd(`AEA_ADDR_STAT, got);
    check("irq status idle", got, 24'h00_0000);
    check("irq with no event", {23'h00_0000, irq_n_out}, 24'h00_0001);
    $display("done register access");
  endtask : t_access

  task automatic t_modes();
    // mode 3 is handled like mode 0
    logic [23:0] want [4] = '{24'h00_0004, 24'h00_0008, 24'h00_0006, 24'h00_0004};
    for (int m = 0; m < 4; m++)
    begin
      set_mode(m[1:0], 3'b111);
      measure(trio(FNEG, HNEG, ZERO, HPOS, FNEG, HNEG), 4, got);
      check("sum mode", got, want[m]);
    end
    set_mode(2'b00, 3'b111);
    $display("done summation modes");
  endtask : t_modes

  task automatic t_select();
    logic [2:0]  sel [4]  = '{3'b100, 3'b011, 3'b101, 3'b000};
    logic [23:0] want [4] = '{24'h00_0002, 24'h00_0004, 24'h00_0004, 24'h00_0000};
    for (int i = 0; i < 4; i++)
    begin
      set_mode(2'b00, sel[i]);
      measure(trio(FNEG, FNEG, FNEG, FNEG, FNEG, FNEG), 2, got);
      check("phase select", got, want[i]);
    end
    set_mode(2'b00, 3'b111);
    $display("done phase select");
  endtask : t_select

  task automatic t_sign();
    measure(trio(FNEG, HPOS, ZERO, ZERO, ZERO, ZERO), 2, got);
    check("negative energy", got, 24'hFF_FFFF);
    @(posedge clk_in);
    samples_in <= trio(FNEG, HPOS, ZERO, ZERO, ZERO, ZERO);
    rd(`AEA_ADDR_FNUM, got);
    check("reverse sign a", got, 24'h00_1000);
    set_mode(2'b00, 3'b011);
    rd(`AEA_ADDR_FNUM, got);
    check("disabled sign", got, 24'h00_0000);
    set_mode(2'b00, 3'b111);
    wr(`AEA_ADDR_GAIN, 24'h00_0004);
    rd(`AEA_ADDR_FNUM, got);
    check("sign in abs mode", got, 24'h00_1000);
    @(posedge clk_in);
    samples_in <= '0;
    measure(trio(FNEG, HPOS, ZERO, ZERO, ZERO, ZERO), 2, got);
    check("absolute sum", got, 24'h00_0001);
    wr(`AEA_ADDR_GAIN, 24'h00_0000);
    $display("done reverse power");
  endtask : t_sign

  task automatic t_div();
    logic [23:0] div [2]  = '{24'h00_0002, 24'h00_0003};
    logic [23:0] want [2] = '{24'h00_0006, 24'h00_0004};
    for (int i = 0; i < 2; i++)
    begin
      wr(`AEA_ADDR_DIV, div[i]);
      measure(trio(FNEG, FNEG, FNEG, FNEG, FNEG, FNEG), 4, got);
      check("divided energy", got, want[i]);
    end
    wr(`AEA_ADDR_DIV, 24'h00_0000);
    $display("done divider");
  endtask : t_div

  task automatic t_clear();
    measure(trio(FNEG, FNEG, ZERO, ZERO, ZERO, ZERO), 5, got);
    check("energy", got, 24'h00_0005);
    rd(`AEA_ADDR_RO, got);
    check("plain reread", got, 24'h00_0005);
    rd(`AEA_ADDR_RC, got);
    check("clearing read", got, 24'h00_0005);
    rd(`AEA_ADDR_RO, got);
    check("after clear", got, 24'h00_0000);
    $display("done read clear");
  endtask : t_clear

  task automatic t_gain();
    wr(`AEA_ADDR_PGAIN, 24'h00_0800);
    measure(trio(FNEG, FNEG, ZERO, ZERO, ZERO, ZERO), 4, got);
    check("power gain", got, 24'h00_0002);
    // power gain goes back to default before watt gain is used
    wr(`AEA_ADDR_PGAIN, 24'h00_0000);
    wr(`AEA_ADDR_PHASE_WATT_GAIN, 24'h00_07FF);
    measure(trio(FNEG, FNEG, ZERO, ZERO, ZERO, ZERO), 4, got);
    check("watt gain", got, 24'h00_0005);
    wr(`AEA_ADDR_PHASE_WATT_GAIN, 24'h00_0000);
    $display("done gain");
  endtask : t_gain

  // a small negative term shows up as all ones in the readout once it is let through
  task automatic t_noload();
    aea_trio_t tiny;
    tiny = trio(16'hFFF0, 16'h0010, ZERO, ZERO, ZERO, ZERO);
    measure(tiny, 2, got);
    check("below threshold", got, 24'h00_0000);
    wr(`AEA_ADDR_GAIN, 24'h00_0008);
    measure(tiny, 2, got);
    check("threshold off", got, 24'hFF_FFFF);
    wr(`AEA_ADDR_POFFS, 24'h00_0100);
    measure(tiny, 2, got);
    check("power offset", got, 24'h00_0000);
    wr(`AEA_ADDR_POFFS, 24'h00_0000);
    wr(`AEA_ADDR_GAIN, 24'h00_0000);
    $display("done no-load threshold");
  endtask : t_noload

  task automatic t_freeze();
    rd(`AEA_ADDR_RC, got);
    @(posedge clk_in);
    ce_in      <= 1'b0;
    samples_in <= trio(FNEG, FNEG, FNEG, FNEG, FNEG, FNEG);
    repeat (`AEA_SAMPLE_CYC * 4) @(posedge clk_in);
    samples_in <= '0;
    ce_in      <= 1'b1;
    rd(`AEA_ADDR_RO, got);
    check("frozen accumulator", got, 24'h00_0000);
    $display("done clock enable");
  endtask : t_freeze

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  initial
  begin
    fail_count = 0;
    cmp_count = 0;
    rst_n_in = 1'b0;
    ce_in = 1'b1;
    samples_in = '0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_access();
    t_modes();
    t_select();
    t_sign();
    t_div();
    t_clear();
    t_gain();
    t_noload();
    t_freeze();
    complete_run();
  end

  // about 83 frames of some 400 clocks each fit well inside this span
  initial
  begin
    repeat (100000) @(posedge clk_in);
    fail_count++;
    $display("watchdog expired");
    complete_run();
  end
endmodule : test_active_energy_accumulator
`default_nettype wire
